// file: dv/hss_master.sv
// Master model: halt bit of the control word and a ramping motor speed.
// Assumes the bench requests halts on falling edges.
`timescale 1ns/1ps
`default_nettype none
module hss_master (
   // Control
   input wire logic i_clk,
   input wire logic i_halt,
   input wire logic i_ramp,
   // Drive side
   output logic [15:0] o_cw,
   output logic [15:0] o_spd
);
   // ---
   // Model
   // ---
   assign o_cw = {7'h00, i_halt, 8'h00};
   always @(negedge i_clk) begin
      if (!i_halt) begin
         o_spd <= 16'h00c8;
      end else if (i_ramp && o_spd > 16'h0011) begin
         o_spd <= o_spd - 16'h0011;
      end
   end
endmodule
`default_nettype wire

// file: dv/hss_top_asserts.sv
// Checker on the halt stop selector ports.
// Assumes it is bound to hss_top below.
`timescale 1ns/1ps
`default_nettype none
module hss_chk (
   // Ports watched
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   input wire logic [15:0] I_DRIVE_CONTROL_WORD,
   input wire hss_pkg::hss_grp_t I_MODE_GRP,
   input wire logic I_OP_ENABLED,
   input wire logic [15:0] I_ACT_SPEED_RPM,
   input wire hss_pkg::hss_prof_t O_STOP_PROF,
   input wire logic [31:0] O_STOP_RATE,
   input wire logic O_STOP_ACTIVE,
   input wire logic O_STOPPED,
   input wire logic O_HOLD_OP_ENABLED
);
   // ---
   // Assertions
   // ---
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   wire logic h = I_DRIVE_CONTROL_WORD[8];
   wire logic run = h && I_OP_ENABLED;
   property p_rise; $rose(O_STOP_ACTIVE) |-> $past(h) && !$past(h, 2) && $past(I_OP_ENABLED); endproperty
   a_rise: assert property (p_rise) else $error("stop began without halt edge");
   property p_dec; O_STOP_ACTIVE |-> O_HOLD_OP_ENABLED && !O_STOPPED; endproperty
   a_dec: assert property (p_dec) else $error("state not held in decel");
   property p_thr; O_STOP_ACTIVE && run && I_ACT_SPEED_RPM <= 16'h001e |=> O_STOPPED; endproperty
   a_thr: assert property (p_thr) else $error("no stop at low speed");
   property p_slow; O_STOP_ACTIVE && run && I_ACT_SPEED_RPM > 16'h001e |=> O_STOP_ACTIVE; endproperty
   a_slow: assert property (p_slow) else $error("stopped above threshold");
   property p_held; O_STOPPED && run |-> O_HOLD_OP_ENABLED ##1 O_STOPPED; endproperty
   a_held: assert property (p_held) else $error("state not held after stop");
   property p_grp; $rose(O_STOP_ACTIVE) |-> $past(I_MODE_GRP) != 2'h3 && O_STOP_PROF != 3'h0; endproperty
   a_grp: assert property (p_grp) else $error("stop with invalid group");
   property p_pv; $rose(O_STOP_ACTIVE) && $past(I_MODE_GRP) == 2'h0 |-> O_STOP_PROF inside {3'h1, 3'h2, 3'h3}; endproperty
   a_pv: assert property (p_pv) else $error("bad pos/vel profile");
   property p_tq; O_STOP_ACTIVE && $past(I_MODE_GRP) == 2'h2 |->
      O_STOP_PROF == 3'h4 || (O_STOP_PROF == 3'h5 && O_STOP_RATE == 32'h0); endproperty
   a_tq: assert property (p_tq) else $error("bad torque profile");
   property p_end; (O_STOP_ACTIVE || O_STOPPED) && !h |=> !O_STOP_ACTIVE && !O_STOPPED; endproperty
   a_end: assert property (p_end) else $error("stop kept after halt cleared");
endmodule
bind hss_top hss_chk u_chk (.I_CLK_SYS, .I_RST, .I_DRIVE_CONTROL_WORD, .I_MODE_GRP, .I_OP_ENABLED,
   .I_ACT_SPEED_RPM, .O_STOP_PROF, .O_STOP_RATE, .O_STOP_ACTIVE, .O_STOPPED, .O_HOLD_OP_ENABLED);
`default_nettype wire

// file: dv/tb_halt_stop_selector.sv
// Testbench for hss_top with the master model.
// Assumes design and dv files compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "hss_map.svh"
module tb_halt_stop_selector;
   // ---
   // Bench
   // ---
   logic clk, rst, we, halt, act, stp, hold, ope;
   logic [15:0] idx, cw, spd;
   logic [31:0] wd, rdat, rate;
   hss_pkg::hss_grp_t grp;
   hss_pkg::hss_prof_t prof;
   int fail_count = 0;
   int n_checks = 0;
   hss_top DUT (.I_CLK_SYS(clk), .I_RST(rst), .I_OBJ_WE(we), .I_OBJ_IDX(idx), .I_OBJ_WDATA(wd),
      .O_OBJ_RDATA(rdat), .I_DRIVE_CONTROL_WORD(cw), .I_MODE_GRP(grp), .I_OP_ENABLED(ope),
      .I_ACT_SPEED_RPM(spd), .O_STOP_PROF(prof), .O_STOP_RATE(rate), .O_STOP_ACTIVE(act),
      .O_STOPPED(stp), .O_HOLD_OP_ENABLED(hold));
   hss_master u_mst (.i_clk(clk), .i_halt(halt), .i_ramp(act), .o_cw(cw), .o_spd(spd));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      idx <= a;
      wd <= d;
      we <= 1'b1;
      @(negedge clk);
      we <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
      idx <= a;
      @(negedge clk);
      chk(rdat, e);
   endtask
   task automatic t_regs();
      rdchk(`HSS_OFS_HALT_SEL, 32'h1);
      rdchk(`HSS_OFS_PROF_DECEL, 32'h0);
      wr(`HSS_OFS_HALT_SEL, 32'hffff_0003);
      rdchk(`HSS_OFS_HALT_SEL, 32'h3);
      rdchk(16'h1234, 32'h0);
   endtask
   task automatic t_halt(input logic [1:0] g, input logic [15:0] s, input logic [2:0] ep, input logic [31:0] er);
      int n;
      wr(`HSS_OFS_HALT_SEL, {16'h0, s});
      grp <= hss_pkg::hss_grp_t'(g);
      halt <= 1'b1;
      @(negedge clk);
      chk({act, hold, stp}, 3'b110);
      chk(prof, ep);
      chk(rate, er);
      n = 0;
      while (stp !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk({stp, act, hold}, 3'b101);
      chk(spd <= 16'h001e, 1'b1);
      chk(n, 32'd10);
      halt <= 1'b0;
      @(negedge clk);
      chk({act, stp, hold}, 3'b000);
   endtask
   task automatic t_refuse(input logic [1:0] g, input logic [15:0] s, input logic e);
      wr(`HSS_OFS_HALT_SEL, {16'h0, s});
      grp <= hss_pkg::hss_grp_t'(g);
      ope <= e;
      halt <= 1'b1;
      repeat (3) @(negedge clk);
      chk({act, stp, hold}, 3'b000);
      halt <= 1'b0;
      ope <= 1'b1;
      @(negedge clk);
   endtask
   task automatic t_rst();
      wr(`HSS_OFS_HALT_SEL, 32'h2);
      grp <= hss_pkg::HSS_GRP_POSVEL;
      halt <= 1'b1;
      repeat (2) @(negedge clk);
      chk(act, 1'b1);
      rst <= 1'b1;
      halt <= 1'b0;
      repeat (2) @(negedge clk);
      chk({act, stp, hold, prof}, 6'h00);
      rst <= 1'b0;
      rdchk(`HSS_OFS_HALT_SEL, 32'h1);
   endtask
   task automatic summarize();
      if (fail_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #50us;
      fail_count++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      we = 1'b0;
      halt = 1'b0;
      ope = 1'b1;
      idx = 16'h0;
      wd = 32'h0;
      grp = hss_pkg::HSS_GRP_POSVEL;
      repeat (16) @(negedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_regs();
      wr(`HSS_OFS_PROF_DECEL, 32'h11);
      wr(`HSS_OFS_QS_DECEL, 32'h22);
      wr(`HSS_OFS_MAX_DECEL, 32'h33);
      wr(`HSS_OFS_TORQ_RAMP, 32'h44);
      wr(`HSS_OFS_HOME_ACCEL, 32'h55);
      t_halt(2'h0, 16'h1, 3'h1, 32'h11);
      t_halt(2'h0, 16'h2, 3'h2, 32'h22);
      t_halt(2'h0, 16'h3, 3'h3, 32'h33);
      t_halt(2'h1, 16'h1, 3'h6, 32'h55);
      t_halt(2'h1, 16'h2, 3'h2, 32'h22);
      t_halt(2'h1, 16'h3, 3'h3, 32'h33);
      t_halt(2'h2, 16'h1, 3'h4, 32'h44);
      t_halt(2'h2, 16'h2, 3'h4, 32'h44);
      t_halt(2'h2, 16'h3, 3'h5, 32'h0);
      t_refuse(2'h0, 16'h0, 1'b1);
      t_refuse(2'h0, 16'h4, 1'b1);
      t_refuse(2'h3, 16'h1, 1'b1);
      t_refuse(2'h0, 16'h1, 1'b0);
      t_rst();
      summarize();
   end
endmodule
`default_nettype wire

// file: hdl/hss_map.svh
// Constants for the halt stop selector: object offsets, field positions, thresholds.
// Assumes inclusion by bare name from design files.
`ifndef HSS_MAP_SVH
`define HSS_MAP_SVH
`define HSS_OFS_HALT_SEL 16'h605d
`define HSS_OFS_PROF_DECEL 16'h6084
`define HSS_OFS_QS_DECEL 16'h6085
`define HSS_OFS_TORQ_RAMP 16'h6087
`define HSS_OFS_HOME_ACCEL 16'h609a
`define HSS_OFS_MAX_DECEL 16'h60c6
`define HSS_CW_HALT_BIT 8
`define HSS_HALT_SEL_RST 16'h0001
`define HSS_RATE_RST 32'h0000_0000
`define HSS_STOP_RPM 16'h001e
`endif

// file: hdl/hss_pkg.sv
// Types for the halt stop selector.
// Assumes hss_map.svh supplies numeric constants.
package hss_pkg;
   typedef enum logic [1:0] {
      HSS_GRP_POSVEL = 2'h0,
      HSS_GRP_HOMING = 2'h1,
      HSS_GRP_TORQUE = 2'h2
   } hss_grp_t;
   typedef enum logic [2:0] {
      HSS_PROF_NONE = 3'h0,
      HSS_PROF_DECEL = 3'h1,
      HSS_PROF_QSTOP = 3'h2,
      HSS_PROF_MAXTQ = 3'h3,
      HSS_PROF_TSLOPE = 3'h4,
      HSS_PROF_ZEROTQ = 3'h5,
      HSS_PROF_HOMACC = 3'h6
   } hss_prof_t;
   typedef enum logic [2:0] {
      HSS_ST_RUN = 3'b001,
      HSS_ST_DECEL = 3'b010,
      HSS_ST_HELD = 3'b100
   } hss_state_t;
endpackage

// file: hdl/hss_profile_sel.sv
// Maps halt option value and mode group to a stop profile and rate.
// Assumes rate inputs come from the register file.
`timescale 1ns/1ps
`default_nettype none
module hss_profile_sel (
   // Selection
   input wire logic [15:0] i_sel,
   input wire hss_pkg::hss_grp_t i_grp,
   // Rates
   input wire logic [31:0] i_prof_decel,
   input wire logic [31:0] i_qs_decel,
   input wire logic [31:0] i_max_decel,
   input wire logic [31:0] i_torq_ramp,
   input wire logic [31:0] i_home_accel,
   // Result
   output hss_pkg::hss_prof_t o_prof,
   output logic [31:0] o_rate
);
   always_comb begin
      o_prof = hss_pkg::HSS_PROF_NONE;
      o_rate = 32'h0000_0000;
      unique case (i_grp)
         hss_pkg::HSS_GRP_POSVEL: begin
            if (i_sel == 16'h0001) begin
               o_prof = hss_pkg::HSS_PROF_DECEL;
               o_rate = i_prof_decel;
            end else if (i_sel == 16'h0002) begin
               o_prof = hss_pkg::HSS_PROF_QSTOP;
               o_rate = i_qs_decel;
            end else if (i_sel == 16'h0003) begin
               o_prof = hss_pkg::HSS_PROF_MAXTQ;
               o_rate = i_max_decel;
            end
         end
         hss_pkg::HSS_GRP_HOMING: begin
            if (i_sel == 16'h0001) begin
               o_prof = hss_pkg::HSS_PROF_HOMACC;
               o_rate = i_home_accel;
            end else if (i_sel == 16'h0002) begin
               o_prof = hss_pkg::HSS_PROF_QSTOP;
               o_rate = i_qs_decel;
            end else if (i_sel == 16'h0003) begin
               o_prof = hss_pkg::HSS_PROF_MAXTQ;
               o_rate = i_max_decel;
            end
         end
         hss_pkg::HSS_GRP_TORQUE: begin
            if (i_sel == 16'h0001 || i_sel == 16'h0002) begin
               o_prof = hss_pkg::HSS_PROF_TSLOPE;
               o_rate = i_torq_ramp;
            end else if (i_sel == 16'h0003) begin
               o_prof = hss_pkg::HSS_PROF_ZEROTQ;
            end
         end
         default: begin
            o_prof = hss_pkg::HSS_PROF_NONE;
         end
      endcase
   end
endmodule
`default_nettype wire

// file: hdl/hss_top.sv
// Halt stop selector: watches the halt bit of the drive control word and
// commands the stop profile chosen by the halt option object.
// Assumes speed and control word are synchronous to I_CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
`include "hss_map.svh"
module hss_top (
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   // Object access
   input wire logic I_OBJ_WE,
   input wire logic [15:0] I_OBJ_IDX,
   input wire logic [31:0] I_OBJ_WDATA,
   output logic [31:0] O_OBJ_RDATA,
   // Drive inputs
   input wire logic [15:0] I_DRIVE_CONTROL_WORD,
   input wire hss_pkg::hss_grp_t I_MODE_GRP,
   input wire logic I_OP_ENABLED,
   input wire logic [15:0] I_ACT_SPEED_RPM,
   // Stop command
   output hss_pkg::hss_prof_t O_STOP_PROF,
   output logic [31:0] O_STOP_RATE,
   output logic O_STOP_ACTIVE,
   output logic O_STOPPED,
   output logic O_HOLD_OP_ENABLED
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0] sel_q, sel_d;
   always_comb begin
      sel_d = sel_q;
      if (I_OBJ_WE && I_OBJ_IDX == `HSS_OFS_HALT_SEL) begin
         sel_d = I_OBJ_WDATA[15:0];
      end
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         sel_q <= `HSS_HALT_SEL_RST;
      end else begin
         sel_q <= sel_d;
      end
   end

   // ----------------------------------------
   // Rate objects
   // ----------------------------------------
   logic [31:0] prof_decel_q, prof_decel_d;
   logic [31:0] qs_decel_q, qs_decel_d;
   logic [31:0] max_decel_q, max_decel_d;
   logic [31:0] torq_ramp_q, torq_ramp_d;
   logic [31:0] home_accel_q, home_accel_d;
   always_comb begin
      prof_decel_d = prof_decel_q;
      qs_decel_d = qs_decel_q;
      max_decel_d = max_decel_q;
      torq_ramp_d = torq_ramp_q;
      home_accel_d = home_accel_q;
      if (I_OBJ_WE) begin
         unique case (I_OBJ_IDX)
            `HSS_OFS_PROF_DECEL: prof_decel_d = I_OBJ_WDATA;
            `HSS_OFS_QS_DECEL: qs_decel_d = I_OBJ_WDATA;
            `HSS_OFS_MAX_DECEL: max_decel_d = I_OBJ_WDATA;
            `HSS_OFS_TORQ_RAMP: torq_ramp_d = I_OBJ_WDATA;
            `HSS_OFS_HOME_ACCEL: home_accel_d = I_OBJ_WDATA;
            default: prof_decel_d = prof_decel_q;
         endcase
      end
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         prof_decel_q <= `HSS_RATE_RST;
         qs_decel_q <= `HSS_RATE_RST;
         max_decel_q <= `HSS_RATE_RST;
         torq_ramp_q <= `HSS_RATE_RST;
         home_accel_q <= `HSS_RATE_RST;
      end else begin
         prof_decel_q <= prof_decel_d;
         qs_decel_q <= qs_decel_d;
         max_decel_q <= max_decel_d;
         torq_ramp_q <= torq_ramp_d;
         home_accel_q <= home_accel_d;
      end
   end

   // ----------------------------------------
   // Object read
   // ----------------------------------------
   logic [31:0] rdata_q, rdata_d;
   always_comb begin
      unique case (I_OBJ_IDX)
         `HSS_OFS_HALT_SEL: rdata_d = {16'h0000, sel_q};
         `HSS_OFS_PROF_DECEL: rdata_d = prof_decel_q;
         `HSS_OFS_QS_DECEL: rdata_d = qs_decel_q;
         `HSS_OFS_MAX_DECEL: rdata_d = max_decel_q;
         `HSS_OFS_TORQ_RAMP: rdata_d = torq_ramp_q;
         `HSS_OFS_HOME_ACCEL: rdata_d = home_accel_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign O_OBJ_RDATA = rdata_q;

   // ----------------------------------------
   // Profile choice
   // ----------------------------------------
   hss_pkg::hss_prof_t sel_prof;
   logic [31:0] sel_rate;
   hss_profile_sel u_sel (
      .i_sel(sel_q),
      .i_grp(I_MODE_GRP),
      .i_prof_decel(prof_decel_q),
      .i_qs_decel(qs_decel_q),
      .i_max_decel(max_decel_q),
      .i_torq_ramp(torq_ramp_q),
      .i_home_accel(home_accel_q),
      .o_prof(sel_prof),
      .o_rate(sel_rate)
   );

   // ----------------------------------------
   // Halt sequence
   // ----------------------------------------
   hss_pkg::hss_state_t st_q, st_d;
   logic halt_q, halt_d;
   hss_pkg::hss_prof_t prof_q, prof_d;
   logic [31:0] rate_q, rate_d;
   logic halt_bit;
   logic slow;
   assign halt_bit = I_DRIVE_CONTROL_WORD[`HSS_CW_HALT_BIT];
   assign slow = (I_ACT_SPEED_RPM <= `HSS_STOP_RPM);

   // ----------------------------------------
   // Halt edge
   // ----------------------------------------
   // Reset level 0 matches the idle halt bit
   always_comb begin
      halt_d = halt_bit;
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         halt_q <= 1'b0;
      end else begin
         halt_q <= halt_d;
      end
   end

   // ----------------------------------------
   // Stop state
   // ----------------------------------------
   // Rate latched at halt start; later writes wait for the next halt
   always_comb begin
      st_d = st_q;
      prof_d = prof_q;
      rate_d = rate_q;
      unique case (st_q)
         hss_pkg::HSS_ST_RUN: begin
            if (halt_bit && !halt_q && I_OP_ENABLED && sel_prof != hss_pkg::HSS_PROF_NONE) begin
               st_d = hss_pkg::HSS_ST_DECEL;
               prof_d = sel_prof;
               rate_d = sel_rate;
            end
         end
         hss_pkg::HSS_ST_DECEL: begin
            if (!halt_bit || !I_OP_ENABLED) begin
               st_d = hss_pkg::HSS_ST_RUN;
               prof_d = hss_pkg::HSS_PROF_NONE;
            end else if (slow) begin
               st_d = hss_pkg::HSS_ST_HELD;
            end
         end
         hss_pkg::HSS_ST_HELD: begin
            if (!halt_bit || !I_OP_ENABLED) begin
               st_d = hss_pkg::HSS_ST_RUN;
               prof_d = hss_pkg::HSS_PROF_NONE;
            end
         end
         default: begin
            st_d = hss_pkg::HSS_ST_RUN;
            prof_d = hss_pkg::HSS_PROF_NONE;
         end
      endcase
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         st_q <= hss_pkg::HSS_ST_RUN;
         prof_q <= hss_pkg::HSS_PROF_NONE;
         rate_q <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
         prof_q <= prof_d;
         rate_q <= rate_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign O_STOP_PROF = prof_q;
   assign O_STOP_RATE = rate_q;
   assign O_STOP_ACTIVE = (st_q == hss_pkg::HSS_ST_DECEL);
   assign O_STOPPED = (st_q == hss_pkg::HSS_ST_HELD);
   assign O_HOLD_OP_ENABLED = (st_q != hss_pkg::HSS_ST_RUN);
endmodule
`default_nettype wire
